// >>> src/smab_pkg.sv
// constants shared by the management access bridge and its host controller
// ======================================================================
package smab_pkg;
    // ==================================================================
    // access slot layout
    localparam int SLOT_COUNT = 8;
    localparam logic [7:0] SLOT_FIRST_INDEX = 8'h20;
    localparam logic [7:0] SLOT_LAST_INDEX = 8'h27;
    localparam logic [31:0] SLOT_RESET = 32'h8c000000;
    localparam int DONE_BIT = 31;
    localparam int TAERR_BIT = 30;
    localparam int FRAME_HI = 29;
    localparam int FRAME_LO = 28;
    localparam int OPC_HI = 27;
    localparam int OPC_LO = 26;
    localparam int PORT_HI = 25;
    localparam int PORT_LO = 21;
    localparam int DEVREG_HI = 20;
    localparam int DEVREG_LO = 16;
    localparam int DATA_HI = 15;
    localparam logic [1:0] FRAME_C45 = 2'h0;
    localparam logic [1:0] FRAME_C22 = 2'h1;
    localparam logic [1:0] OPC_ADDR = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h3;
    localparam logic [1:0] OPC_READ_INC = 2'h2;
    // ==================================================================
    // serial management frame
    localparam int FRAME_BITS = 64;
    localparam int PREAMBLE_BITS = 32;
    localparam int TA_FIRST = 46;
    localparam int TA_SECOND = 47;
    localparam logic [1:0] C22_WIRE_WRITE = 2'h1;
    localparam logic [1:0] C22_WIRE_READ = 2'h2;
    localparam logic [1:0] TA_WRITE = 2'h2;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int MDC_DIV = (MDC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==================================================================
    // host controller registers on the software bus
    localparam logic [7:0] HOST_SLOT_SEL = 8'h00;
    localparam logic [7:0] HOST_CMD = 8'h04;
    localparam logic [7:0] HOST_LAUNCH = 8'h08;
    localparam logic [7:0] HOST_RESULT = 8'h0c;
    localparam logic [7:0] HOST_STATUS = 8'h10;
    localparam logic [7:0] HOST_IRQ_STATUS = 8'h14;
    localparam logic [7:0] HOST_IRQ_MASK = 8'h18;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_TAERR_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/smab_link_if.sv
// register access port between the host controller and the bridge
`timescale 1ns/1ps
interface smab_link_if;
    logic req;
    logic wr;
    logic [2:0] slot;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    modport dev (input req, input wr, input slot, input wdata, output ack, output rdata);
    modport host (output req, output wr, output slot, output wdata, input ack, input rdata);
endinterface

// >>> src/smab_bridge.sv
// management access bridge: eight access slots and the serial management master
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module smab_bridge
    import smab_pkg::*;
#(
    parameter int MDC_DIVIDE = MDC_DIV
)
(
    input wire logic aclk,
    input wire logic aresetn,
    smab_link_if.dev link,
    output logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    output logic busy
);
    // elaboration guard: the divider counter is eight bits wide
    if (MDC_DIVIDE < 4 || MDC_DIVIDE > 256 || MDC_DIVIDE % 2 != 0)
        $error("MDC_DIVIDE must be even, at least 4 and at most 256");

    typedef enum logic [0:0] {SMAB_IDLE = 1'b0, SMAB_SHIFT = 1'b1} smab_state_e;

    logic [31:0] slots [SLOT_COUNT];
    smab_state_e state;
    logic [2:0] cur;
    logic [5:0] bit_cnt;
    logic [7:0] div_cnt;
    logic [63:0] frame;
    logic is_read;
    logic taerr;
    logic [15:0] rd_shift;
    logic mdio_s1;
    logic mdio_s2;
    logic pend_any;
    logic [2:0] pend_slot;
    logic rise_en;
    logic fall_en;
    logic last_bit;
    logic launch_ok;

    // ==================================================================
    // helpers
    function automatic logic [63:0] build_frame(input logic [31:0] w);
        logic [1:0] op_wire;
        logic rd;
        op_wire = w[OPC_HI:OPC_LO];
        rd = w[OPC_HI];
        if (w[FRAME_HI:FRAME_LO] == FRAME_C22)
            op_wire = rd ? C22_WIRE_READ : C22_WIRE_WRITE;
        build_frame = {{PREAMBLE_BITS{1'b1}}, w[FRAME_HI:FRAME_LO], op_wire,
            w[PORT_HI:PORT_LO], w[DEVREG_HI:DEVREG_LO], TA_WRITE, w[DATA_HI:0]};
    endfunction

    // ==================================================================
    // pin input synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end
        else
        begin
            mdio_s1 <= mdio_i;
            mdio_s2 <= mdio_s1;
        end
    end

    // ==================================================================
    // pending slot pick: lowest index waiting with done clear
    always_comb
    begin
        pend_any = 1'b0;
        pend_slot = 3'h0;
        for (int i = SLOT_COUNT - 1; i >= 0; i--)
        begin
            if (!slots[i][DONE_BIT])
            begin
                pend_any = 1'b1;
                pend_slot = i[2:0];
            end
        end
    end

    assign rise_en = (state == SMAB_SHIFT) && (div_cnt == 8'(MDC_DIVIDE / 2 - 1));
    assign fall_en = (state == SMAB_SHIFT) && (div_cnt == 8'(MDC_DIVIDE - 1));
    assign last_bit = bit_cnt == 6'(FRAME_BITS - 1);
    // a slot with a transaction waiting or running ignores writes until done
    assign launch_ok = link.req && link.wr && !link.ack && slots[link.slot][DONE_BIT];
    assign busy = state == SMAB_SHIFT;

    // ==================================================================
    // register port
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            link.ack <= 1'b0;
            link.rdata <= 32'h0;
        end
        else
        begin
            link.ack <= link.req && !link.ack;
            if (link.req && !link.wr && !link.ack)
                link.rdata <= slots[link.slot];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < SLOT_COUNT; i++)
                slots[i] <= SLOT_RESET;
        end
        else
        begin
            if (launch_ok)
            begin
                // the error flag is read only; a new launch clears it
                slots[link.slot] <= {link.wdata[DONE_BIT], 1'b0, link.wdata[FRAME_HI:0]};
            end
            if (state == SMAB_SHIFT && rise_en && last_bit)
            begin
                slots[cur][DONE_BIT] <= 1'b1;
                slots[cur][TAERR_BIT] <= taerr || (is_read && bit_cnt == 6'(TA_SECOND) && mdio_s2);
                if (is_read)
                    slots[cur][DATA_HI:0] <= {rd_shift[14:0], mdio_s2};
            end
        end
    end

    // ==================================================================
    // serial frame engine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= SMAB_IDLE;
            cur <= 3'h0;
            bit_cnt <= 6'h0;
            div_cnt <= 8'h0;
            frame <= 64'h0;
            is_read <= 1'b0;
            taerr <= 1'b0;
            rd_shift <= 16'h0;
        end
        else
        begin
            unique case (state)
                SMAB_IDLE:
                begin
                    if (pend_any)
                    begin
                        state <= SMAB_SHIFT;
                        cur <= pend_slot;
                        frame <= build_frame(slots[pend_slot]);
                        is_read <= slots[pend_slot][OPC_HI];
                        bit_cnt <= 6'h0;
                        div_cnt <= 8'h0;
                        taerr <= 1'b0;
                    end
                end
                SMAB_SHIFT:
                begin
                    div_cnt <= fall_en ? 8'h0 : div_cnt + 8'h1;
                    if (rise_en)
                    begin
                        // the far end must pull the second turnaround bit low
                        if (is_read && bit_cnt == 6'(TA_SECOND) && mdio_s2)
                            taerr <= 1'b1;
                        if (is_read && bit_cnt > 6'(TA_SECOND))
                            rd_shift <= {rd_shift[14:0], mdio_s2};
                    end
                    if (fall_en)
                    begin
                        bit_cnt <= bit_cnt + 6'h1;
                        // end after the last high half so mdc keeps its full period
                        if (last_bit)
                            state <= SMAB_IDLE;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // pins: data changes while the clock is low, sampled at its rise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mdc <= 1'b0;
            mdio_o <= 1'b1;
            mdio_oe <= 1'b0;
        end
        else
        begin
            if (rise_en)
                mdc <= 1'b1;
            else if (fall_en || state == SMAB_IDLE)
                mdc <= 1'b0;
            if (state == SMAB_SHIFT)
            begin
                mdio_o <= frame[6'(FRAME_BITS - 1) - bit_cnt];
                mdio_oe <= !(is_read && bit_cnt >= 6'(TA_FIRST));
            end
            else
            begin
                mdio_o <= 1'b1;
                mdio_oe <= 1'b0;
            end
        end
    end
endmodule

// >>> src/smab_host.sv
// host controller: software orders over AXI4-Lite become slot launches and polls
`timescale 1ns/1ps
module smab_host
    import smab_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    smab_link_if.host link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    typedef enum logic [1:0] {SMAB_H_IDLE = 2'b00, SMAB_H_LAUNCH = 2'b01,
        SMAB_H_POLL = 2'b10} smab_host_e;

    smab_host_e state;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic w_held;
    logic [2:0] slot_sel;
    logic [29:0] cmd;
    logic [31:0] result;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic do_write;
    logic go;
    logic ev_done;
    logic ev_taerr;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign go = do_write && aw_addr == HOST_LAUNCH && state == SMAB_H_IDLE;
    assign ev_done = state == SMAB_H_POLL && link.ack && link.rdata[DONE_BIT];
    assign ev_taerr = ev_done && link.rdata[TAERR_BIT];
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    // a set mask bit silences its event
    assign irq = |(irq_status & ~irq_mask);

    // ==================================================================
    // software bus: address and data latched independently
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_addr > HOST_IRQ_MASK || aw_addr[1:0] != 2'h0 ?
                    RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slot_sel <= 3'h0;
            cmd <= SLOT_RESET[29:0];
            irq_mask <= 2'h0;
            irq_status <= 2'h0;
        end
        else
        begin
            if (do_write && aw_addr == HOST_SLOT_SEL && s_axi_wstrb[0])
                slot_sel <= w_data[2:0];
            if (do_write && aw_addr == HOST_CMD)
                cmd <= w_data[29:0];
            if (do_write && aw_addr == HOST_IRQ_MASK && s_axi_wstrb[0])
                irq_mask <= w_data[1:0];
            // a new event wins over a clear in the same cycle
            irq_status <= ((do_write && aw_addr == HOST_IRQ_STATUS && s_axi_wstrb[0]) ?
                irq_status & ~w_data[1:0] : irq_status) | {ev_taerr, ev_done};
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                HOST_SLOT_SEL: s_axi_rdata <= {29'h0, slot_sel};
                HOST_CMD: s_axi_rdata <= {2'h0, cmd};
                HOST_LAUNCH: s_axi_rdata <= 32'h0;
                HOST_RESULT: s_axi_rdata <= result;
                HOST_STATUS: s_axi_rdata <= {31'h0, state != SMAB_H_IDLE};
                HOST_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status};
                HOST_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ==================================================================
    // launch then poll the slot until its done flag returns
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= SMAB_H_IDLE;
            link.req <= 1'b0;
            link.wr <= 1'b0;
            link.slot <= 3'h0;
            link.wdata <= 32'h0;
            result <= SLOT_RESET;
        end
        else
        begin
            unique case (state)
                SMAB_H_IDLE:
                begin
                    if (go)
                    begin
                        state <= SMAB_H_LAUNCH;
                        link.req <= 1'b1;
                        link.wr <= 1'b1;
                        link.slot <= slot_sel;
                        // reads carry zero data; other ops carry data or address
                        link.wdata <= {1'b0, 1'b0, cmd[FRAME_HI:DEVREG_LO],
                            cmd[OPC_HI] ? 16'h0 : cmd[DATA_HI:0]};
                    end
                end
                SMAB_H_LAUNCH:
                begin
                    if (link.ack)
                    begin
                        state <= SMAB_H_POLL;
                        link.wr <= 1'b0;
                    end
                end
                SMAB_H_POLL:
                begin
                    if (ev_done)
                    begin
                        state <= SMAB_H_IDLE;
                        link.req <= 1'b0;
                        result <= {link.rdata[31:16],
                            (link.rdata[TAERR_BIT] && link.rdata[OPC_HI]) ?
                            16'h0 : link.rdata[DATA_HI:0]};
                    end
                end
                default:
                    state <= SMAB_H_IDLE;
            endcase
        end
    end
endmodule

// >>> verif/smab_link_properties.sv
// concurrent checks on the bridge link and the serial management pins
`timescale 1ns/1ps
module smab_link_properties
#(
    parameter int MDC_DIVIDE = 16
)
(
    input logic aclk,
    input logic aresetn,
    input logic req,
    input logic wr,
    input logic [2:0] slot,
    input logic [31:0] wdata,
    input logic ack,
    input logic [31:0] rdata,
    input logic mdc,
    input logic mdio_o,
    input logic mdio_oe,
    input logic busy
);
    int hi_cnt;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==================================================================
    // helper logic
    // the clock high time spans more cycles than a repetition may hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !mdc)
            hi_cnt <= 0;
        else
            hi_cnt <= hi_cnt + 1;
    end

    sequence s_launch;
        req && wr && !ack && !wdata[31] && !busy;
    endsequence

    sequence s_preamble;
        (mdio_oe && mdio_o) [*8];
    endsequence

    // ==================================================================
    // link handshake
    a_ack_answer: assert property (req && !ack |=> ack)
        else $error("link request not answered in the next cycle");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("link answer held longer than one cycle");
    a_req_hold: assert property (req && !ack |=> req && $stable({wr, slot, wdata}))
        else $error("link request changed before its answer");
    a_rdata_cause: assert property ($changed(rdata) |-> $past(req && !wr && !ack))
        else $error("slot word changed without a read request");

    // ==================================================================
    // launch and serial frame
    a_launch_start: assert property (s_launch |-> ##[1:4] busy)
        else $error("cleared done bit did not start a frame");
    a_read_zero: assert property (req && wr && wdata[27] && !wdata[31] |-> !(|wdata[15:0]))
        else $error("read launched with a nonzero data field");
    a_preamble_ones: assert property ($rose(busy) |-> ##[0:3] s_preamble)
        else $error("frame does not open with driven ones");
    a_mdc_half: assert property ($fell(mdc) |-> hi_cnt == MDC_DIVIDE / 2)
        else $error("management clock high time wrong");
endmodule

// >>> verif/spi_to_mdio_access_bridge_bench.sv
// self-checking bench: host controller and bridge joined over the link
`timescale 1ns/1ps
module spi_to_mdio_access_bridge_bench
    import smab_pkg::*;
;
    localparam int DIV = 16;
    logic aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r, aw_r, w_r, b_v, ar_r, r_v, irq;
    logic mdc, mdio_i, mdio_o, mdio_oe, busy, phy_on, phy_drv, mdc_q, mdio_q;
    logic [7:0] aw_a, ar_a;
    logic [31:0] w_d, r_d, rdv;
    logic [3:0] w_s;
    logic [1:0] b_resp, r_resp, resp, irq_mask;
    logic [15:0] phy_data;
    logic [63:0] seen;
    int rises, n_fail, n_compared;

    smab_link_if smab_link_if_i ();
    smab_host smab_host_i (.aclk(aclk), .aresetn(aresetn), .link(smab_link_if_i.host),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .irq(irq));
    smab_bridge #(.MDC_DIVIDE(DIV)) smab_bridge_i (.aclk(aclk), .aresetn(aresetn),
        .link(smab_link_if_i.dev), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .busy(busy));
    smab_link_properties #(.MDC_DIVIDE(DIV)) smab_link_properties_i (.aclk(aclk),
        .aresetn(aresetn), .req(smab_link_if_i.req), .wr(smab_link_if_i.wr),
        .slot(smab_link_if_i.slot), .wdata(smab_link_if_i.wdata), .ack(smab_link_if_i.ack),
        .rdata(smab_link_if_i.rdata), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .busy(busy));

    // pulled-up wire: a released line reads one, which also marks a missing answer
    assign mdio_i = mdio_oe ? mdio_o : phy_drv;

    // ==================================================================
    // far-end stand-in: records the wire, answers reads after the turnaround
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mdc_q <= 1'b0;
            mdio_q <= 1'b1;
            rises <= 0;
            seen <= 64'h0;
            phy_drv <= 1'b1;
        end
        else
        begin
            mdc_q <= mdc;
            mdio_q <= mdio_i;
            if (mdc && !mdc_q)
            begin
                rises <= rises + 1;
                seen <= {seen[62:0], mdio_q};
            end
            else if (!busy)
            begin
                rises <= 0;
                phy_drv <= 1'b1;
            end
            else if (!mdc && mdc_q && phy_on && rises >= 47 && rises < 64)
                phy_drv <= rises > 47 && phy_data[63 - rises];
        end
    end

    // ==================================================================
    // access tasks
    task automatic check(input string nm, input logic [31:0] sn, input logic [31:0] ex);
        n_compared++;
        if (sn !== ex)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_hit;
        logic w_hit;
        @(posedge aclk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do
        begin
            @(negedge aclk);
            aw_hit = aw_v && aw_r;
            w_hit = w_v && w_r;
            @(posedge aclk);
            if (aw_hit) aw_v <= 1'b0;
            if (w_hit) w_v <= 1'b0;
        end while ((aw_v && !aw_hit) || (w_v && !w_hit));
        do @(negedge aclk); while (!b_v);
        resp = b_resp;
        @(posedge aclk);
        b_r <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do @(negedge aclk); while (!ar_r);
        @(posedge aclk);
        ar_v <= 1'b0;
        do @(negedge aclk); while (!r_v);
        rdv = r_d;
        resp = r_resp;
        @(posedge aclk);
        r_r <= 1'b0;
    endtask

    task automatic run_op(input logic [2:0] sl, input logic [1:0] fr, input logic [1:0] op,
        input logic [4:0] pa, input logic [4:0] dv, input logic [15:0] dt, input logic on,
        input logic [15:0] pd);
        logic rd;
        logic te;
        logic [15:0] wd;
        rd = op[1];
        te = rd && !on;
        wd = rd ? (on ? pd : 16'hffff) : dt;
        phy_on <= on;
        phy_data <= pd;
        axi_wr(HOST_SLOT_SEL, {29'h0, sl});
        axi_wr(HOST_CMD, {2'h0, fr, op, pa, dv, dt});
        axi_wr(HOST_LAUNCH, 32'h1);
        do axi_rd(HOST_STATUS); while (rdv[0] !== 1'b0);
        check("preamble", seen[63:32], 32'hffffffff);
        check("frame", seen[31:0], {fr, fr == FRAME_C22 ? {rd, !rd} : op, pa, dv, 1'b1, te, wd});
        axi_rd(HOST_RESULT);
        check("result", rdv, {1'b1, te, fr, op, pa, dv, te ? 16'h0 : (rd ? pd : dt)});
        @(negedge aclk);
        check("irq", {31'h0, irq}, {31'h0, |({te, 1'b1} & ~irq_mask)});
        axi_rd(HOST_IRQ_STATUS);
        check("irq status", rdv, {30'h0, te, 1'b1});
        axi_wr(HOST_IRQ_STATUS, 32'h3);
        @(negedge aclk);
        check("irq clear", {31'h0, irq}, 32'h0);
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==================================================================
    // clock, watchdog and tests
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        test_done;
    end

    initial
    begin
        {aresetn, aw_v, w_v, b_r, ar_v, r_r, phy_on} = '0;
        {aw_a, ar_a, w_d, phy_data, irq_mask, n_fail, n_compared} = '0;
        w_s = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(HOST_CMD);
        check("cmd reset", rdv, 32'h0c000000);
        axi_rd(HOST_IRQ_MASK);
        check("mask reset", rdv, 32'h0);
        axi_rd(8'h1c);
        check("unmapped read", {rdv[29:0], resp}, {30'h0, RESP_SLVERR});
        axi_wr(8'h06, 32'h0);
        check("unaligned write", {30'h0, resp}, {30'h0, RESP_SLVERR});
        run_op(3'h3, FRAME_C45, OPC_WRITE, 5'h0a, 5'h05, 16'ha5c3, 1'b0, 16'h0);
        run_op(3'h7, FRAME_C45, OPC_READ, 5'h1f, 5'h1e, 16'h1234, 1'b1, 16'h3c5a);
        irq_mask = 2'h1;
        axi_wr(HOST_IRQ_MASK, {30'h0, irq_mask});
        run_op(3'h0, FRAME_C22, OPC_READ, 5'h11, 5'h0f, 16'h0, 1'b0, 16'h0);
        irq_mask = 2'h3;
        axi_wr(HOST_IRQ_MASK, {30'h0, irq_mask});
        run_op(3'h5, FRAME_C45, OPC_ADDR, 5'h01, 5'h02, 16'h8001, 1'b0, 16'h0);
        irq_mask = 2'h0;
        axi_wr(HOST_IRQ_MASK, {30'h0, irq_mask});
        run_op(3'h1, FRAME_C45, OPC_READ_INC, 5'h02, 5'h03, 16'h0, 1'b1, 16'hc3a5);
        run_op(3'h3, FRAME_C22, OPC_WRITE, 5'h15, 5'h0a, 16'h5aa5, 1'b0, 16'h0);
        test_done;
    end
endmodule
